//--- rtl/jtm_pkg.sv
package jtm_pkg;
   // ***************************************************
   //  bus shape
   // ***************************************************
   localparam int unsigned IDX_W  = 3;
   localparam int unsigned DATA_W = 8;
   localparam logic [7:0]  BUS_IDLE = 8'hff;  // pulled-up bus level

   // ***************************************************
   //  register indices
   // ***************************************************
   localparam logic [2:0] IDX_CMD  = 3'h0;
   localparam logic [2:0] IDX_MODE = 3'h1;
   localparam logic [2:0] IDX_DIV  = 3'h2;
   localparam logic [2:0] IDX_SCAN = 3'h3;
   localparam logic [2:0] IDX_TMS  = 3'h4;
   localparam logic [2:0] IDX_LEN  = 3'h5;
   localparam logic [2:0] IDX_DISC = 3'h6;
   localparam logic [2:0] IDX_STAT = 3'h7;

   // ***************************************************
   //  field positions and codes
   // ***************************************************
   localparam int unsigned CMD_TRST_BIT  = 0;
   localparam int unsigned DISC_TMS_BIT  = 0;
   localparam int unsigned DISC_TDO_BIT  = 1;
   localparam int unsigned DISC_TRST_BIT = 2;
   localparam logic [1:0]  MODE_GATED = 2'h0;
   localparam logic [1:0]  MODE_FREE  = 2'h1;
   localparam logic [1:0]  MODE_DISC  = 2'h2;

   // ***************************************************
   //  reset values
   // ***************************************************
   localparam logic [7:0] DIV_RST  = 8'h07;  // half period 8: clk/16
   localparam logic [7:0] DIV_MIN  = 8'h02;  // keeps tdi sync inside half
   localparam logic [2:0] LEN_RST  = 3'h7;   // eight bits per scan
   localparam int unsigned RST_DIV_W = 4;    // clk/16 prescaler in reset

   // ***************************************************
   //  host timing
   // ***************************************************
   localparam int unsigned CLK_PERIOD_NS  = 100;
   localparam int unsigned HOST_ACCESS_STROBE_N_LOW_NS    = 800;
   localparam int unsigned HOST_ACCESS_STROBE_N_HIGH_NS   = 600;
   localparam int unsigned HOST_ACCESS_STROBE_N_LOW_CYC   =
      (HOST_ACCESS_STROBE_N_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned HOST_ACCESS_STROBE_N_HIGH_CYC  =
      (HOST_ACCESS_STROBE_N_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [3:0]  HOST_CNT_ONE   = 4'h1;
endpackage

//--- rtl/jtm_if.sv
`timescale 1ns/1ns
interface jtm_if;
   import jtm_pkg::*;
   logic              host_access_strobe_n;
   logic              rw;
   logic [IDX_W-1:0]  host_register_index;
   logic [DATA_W-1:0] host_out;
   logic              host_oe_n;
   logic [DATA_W-1:0] dev_out;
   logic              dev_oe_n;
   logic              ready;
   logic [DATA_W-1:0] host_data_bus;

   // resolved wire: device, then host, else pulled up
   assign host_data_bus = !dev_oe_n  ? dev_out  :
                          !host_oe_n ? host_out : BUS_IDLE;

   modport host (output host_access_strobe_n, rw, host_register_index,
                 output host_out, host_oe_n,
                 input  ready, host_data_bus);
   modport device (input  host_access_strobe_n, rw, host_register_index,
                   input  host_data_bus,
                   output dev_out, dev_oe_n, ready);
endinterface // jtm_if

//--- rtl/jtm_device.sv
`timescale 1ns/1ns
module jtm_device
   import jtm_pkg::*;
(
   input  wire logic  clk_i,
   input  wire logic  arst_n_i,
   jtm_if.device      bus,
   input  wire logic  tdi_i,
   input  wire logic  tap_output_enable_n_i,
   output logic       tck_o,
   output logic       tms_o,
   output logic       tdo_o,
   output logic       trst_o,
   output logic       tap_oe_n_o
);
   // ***************************************************
   //  state
   // ***************************************************
   typedef enum logic [1:0] {JTM_HS_IDLE, JTM_HS_WAIT, JTM_HS_DONE} jtm_hs_e;

   typedef struct packed {
      logic              rst_m, rst_s;
      logic              host_access_strobe_n_m, host_access_strobe_n_s, host_access_strobe_n_p;
      logic              rw_m, rw_s;
      logic [IDX_W-1:0]  idx_m, idx_s;
      logic [DATA_W-1:0] dat_m, dat_s;
      logic              tdi_m, tdi_s;
      logic              toe_m, toe_s;
      jtm_hs_e           hs;
      logic              ready;
      logic [DATA_W-1:0] dout;
      logic              dout_oe_n;
      logic              tap_oe_n;
      logic              tck, tms, tdo, trst;
      logic [1:0]        mode;
      logic [7:0]        div, cnt;
      logic [7:0]        sh_tdo, sh_tms, sh_tdi;
      logic [2:0]        len, bits;
      logic              busy, armed, tdi_last;
   } jtm_dev_s;

   localparam jtm_dev_s DEV_RST = '{
      rst_m: 1'b0, rst_s: 1'b0,
      host_access_strobe_n_m: 1'b1, host_access_strobe_n_s: 1'b1, host_access_strobe_n_p: 1'b1,
      rw_m: 1'b1, rw_s: 1'b1, idx_m: '0, idx_s: '0,
      dat_m: '0, dat_s: '0, tdi_m: 1'b1, tdi_s: 1'b1,
      toe_m: 1'b1, toe_s: 1'b1, hs: JTM_HS_IDLE,
      ready: 1'b1, dout: '0, dout_oe_n: 1'b1, tap_oe_n: 1'b1,
      tck: 1'b1, tms: 1'b1, tdo: 1'b1, trst: 1'b1,
      mode: MODE_GATED, div: DIV_RST, cnt: '0,
      sh_tdo: '0, sh_tms: '0, sh_tdi: '0,
      len: LEN_RST, bits: '0, busy: 1'b0, armed: 1'b0,
      tdi_last: 1'b0};

   jtm_dev_s cur, nx;
   logic [RST_DIV_W-1:0] div16 = '0;
   logic                 tck_pin = 1'b1;
   logic                 fell, rose, blocked, do_acc, run;
   logic                 tck_rise, tck_fall;

   // ***************************************************
   //  next state
   // ***************************************************
   always_comb begin
      nx = cur;
      // pin inputs through two flops before any use
      nx.rst_m  = 1'b1;
      nx.rst_s  = cur.rst_m;
      nx.host_access_strobe_n_m = bus.host_access_strobe_n;
      nx.host_access_strobe_n_s = cur.host_access_strobe_n_m;
      nx.host_access_strobe_n_p = cur.host_access_strobe_n_s;
      nx.rw_m   = bus.rw;
      nx.rw_s   = cur.rw_m;
      nx.idx_m  = bus.host_register_index;
      nx.idx_s  = cur.idx_m;
      nx.dat_m  = bus.host_data_bus;
      nx.dat_s  = cur.dat_m;
      nx.tdi_m  = tdi_i;
      nx.tdi_s  = cur.tdi_m;
      nx.toe_m  = tap_output_enable_n_i;
      nx.toe_s  = cur.toe_m;
      nx.tap_oe_n  = cur.toe_s;
      nx.dout_oe_n = ~(cur.rw_s & ~cur.host_access_strobe_n_s);

      // tck divider; gated mode stops it between scans
      tck_rise = 1'b0;
      tck_fall = 1'b0;
      run = (cur.mode == MODE_FREE) ||
            (cur.mode == MODE_GATED && cur.busy);
      if (cur.mode != MODE_DISC) begin
         if (run) begin
            if (cur.cnt >= cur.div) begin
               nx.cnt   = '0;
               nx.tck   = ~cur.tck;
               tck_rise = ~cur.tck;
               tck_fall = cur.tck;
            end else begin
               nx.cnt = cur.cnt + 8'h01;
            end
         end else begin
            nx.cnt = '0;
         end
      end

      // scan engine, lsb first; tdi fills from the top
      if (cur.busy && tck_fall) begin
         nx.tdo    = cur.sh_tdo[0];
         nx.tms    = cur.sh_tms[0];
         nx.sh_tdo = {1'b0, cur.sh_tdo[7:1]};
         nx.sh_tms = {cur.sh_tms[7], cur.sh_tms[7:1]};
         nx.armed  = 1'b1;
      end
      if (cur.busy && tck_rise && cur.armed) begin
         nx.sh_tdi   = {cur.tdi_s, cur.sh_tdi[7:1]};
         nx.tdi_last = cur.tdi_s;
         nx.armed    = 1'b0;
         if (cur.bits == cur.len) begin
            nx.busy = 1'b0;
            nx.bits = '0;
         end else begin
            nx.bits = cur.bits + 3'h1;
         end
      end

      // host handshake; scan registers wait for the engine
      fell    = cur.host_access_strobe_n_p & ~cur.host_access_strobe_n_s;
      rose    = ~cur.host_access_strobe_n_p & cur.host_access_strobe_n_s;
      blocked = cur.busy && (cur.idx_s == IDX_SCAN ||
                cur.idx_s == IDX_TMS || cur.idx_s == IDX_LEN);
      do_acc  = 1'b0;
      unique case (cur.hs)
         JTM_HS_IDLE: begin
            if (fell) begin
               if (blocked) begin
                  nx.ready = 1'b0;
                  nx.hs    = JTM_HS_WAIT;
               end else begin
                  do_acc = 1'b1;
                  nx.hs  = JTM_HS_DONE;
               end
            end
         end
         JTM_HS_WAIT: begin
            if (!rose && !blocked) begin
               do_acc   = 1'b1;
               nx.ready = 1'b1;
               nx.hs    = JTM_HS_DONE;
            end
         end
         JTM_HS_DONE: ;
      endcase
      if (rose) begin
         nx.ready = 1'b1;
         nx.hs    = JTM_HS_IDLE;
      end

      // register access, index used as is
      if (do_acc && !cur.rw_s) begin
         unique case (cur.idx_s)
            IDX_CMD:  nx.trst = ~cur.dat_s[CMD_TRST_BIT];
            IDX_MODE: nx.mode = cur.dat_s[1:0];
            IDX_DIV:  nx.div  = (cur.dat_s < DIV_MIN) ? DIV_MIN
                                                      : cur.dat_s;
            IDX_SCAN: begin
               nx.sh_tdo = cur.dat_s;
               if (cur.mode != MODE_DISC) begin
                  nx.busy   = 1'b1;
                  nx.bits   = '0;
                  nx.armed  = 1'b0;
                  nx.sh_tdi = '0;
               end
            end
            IDX_TMS:  nx.sh_tms = cur.dat_s;
            IDX_LEN:  nx.len    = cur.dat_s[2:0];
            IDX_DISC: begin
               if (cur.mode == MODE_DISC) begin
                  nx.tck  = 1'b0;
                  nx.tms  = cur.dat_s[DISC_TMS_BIT];
                  nx.tdo  = cur.dat_s[DISC_TDO_BIT];
                  nx.trst = cur.dat_s[DISC_TRST_BIT];
               end
            end
            IDX_STAT: ;
         endcase
      end
      if (do_acc && cur.rw_s) begin
         unique case (cur.idx_s)
            IDX_CMD:  nx.dout = {7'h00, ~cur.trst};
            IDX_MODE: nx.dout = {6'h00, cur.mode};
            IDX_DIV:  nx.dout = cur.div;
            IDX_SCAN: nx.dout = cur.sh_tdi;
            IDX_TMS:  nx.dout = cur.sh_tms;
            IDX_LEN:  nx.dout = {5'h00, cur.len};
            IDX_DISC: begin
               nx.dout = {7'h00, cur.tdi_s};
               if (cur.mode == MODE_DISC) begin
                  nx.tck      = 1'b1;
                  nx.tdi_last = cur.tdi_s;
               end
            end
            IDX_STAT: nx.dout = {4'h0, cur.mode, cur.tdi_last, cur.busy};
         endcase
      end
   end

   // ***************************************************
   //  registers
   // ***************************************************
   // whole cur state held at constants while reset is low
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cur <= DEV_RST;
      end else begin
         cur <= nx;
      end
   end

   // no reset here on purpose: must keep running in reset
   always_ff @(posedge clk_i) begin
      div16   <= div16 + 4'h1;
      tck_pin <= cur.rst_s ? nx.tck : div16[RST_DIV_W-1];
   end

   // ***************************************************
   //  outputs
   // ***************************************************
   assign bus.ready    = cur.ready;
   assign bus.dev_out  = cur.dout;
   assign bus.dev_oe_n = cur.dout_oe_n;
   assign tck_o        = tck_pin;
   assign tms_o        = cur.tms;
   assign tdo_o        = cur.tdo;
   assign trst_o       = cur.trst;
   assign tap_oe_n_o   = cur.tap_oe_n;
endmodule // jtm_device

//--- rtl/jtm_host.sv
`timescale 1ns/1ns
module jtm_host
   import jtm_pkg::*;
#(
   parameter int unsigned LOW_CYC  = HOST_ACCESS_STROBE_N_LOW_CYC,
   parameter int unsigned HIGH_CYC = HOST_ACCESS_STROBE_N_HIGH_CYC
)(
   input  wire logic              clk_i,
   input  wire logic              arst_n_i,
   jtm_if.host                    bus,
   input  wire logic              req_i,
   input  wire logic              rd_i,
   input  wire logic [IDX_W-1:0]  idx_i,
   input  wire logic [DATA_W-1:0] wdata_i,
   output logic                   busy_o,
   output logic                   done_o,
   output logic [DATA_W-1:0]      rdata_o
);
   // device needs ~6 cycles to answer, 3 to see the rise
   if (LOW_CYC < 7 || LOW_CYC > 15 || HIGH_CYC < 4 || HIGH_CYC > 15) begin
      $error("jtm_host: strobe timing out of range");
   end

   // ***************************************************
   //  state
   // ***************************************************
   typedef enum logic [1:0] {JTM_HO_IDLE, JTM_HO_SETUP, JTM_HO_LOW,
                             JTM_HO_HIGH} jtm_ho_e;

   typedef struct packed {
      jtm_ho_e           st;
      logic              strobe_n, rw, oe_n;
      logic [IDX_W-1:0]  idx;
      logic [DATA_W-1:0] wdata;
      logic              rdy_m, rdy_s;
      logic [DATA_W-1:0] dat_m, dat_s;
      logic [3:0]        cnt;
      logic              busy, done;
      logic [DATA_W-1:0] rdata;
   } jtm_host_s;

   localparam jtm_host_s HOST_RST = '{
      st: JTM_HO_IDLE, strobe_n: 1'b1, rw: 1'b1, oe_n: 1'b1,
      idx: '0, wdata: '0, rdy_m: 1'b1, rdy_s: 1'b1,
      dat_m: '0, dat_s: '0, cnt: '0, busy: 1'b0, done: 1'b0,
      rdata: '0};
   localparam logic [3:0] LOW_LAST  = 4'(LOW_CYC - 1);
   localparam logic [3:0] HIGH_LAST = 4'(HIGH_CYC - 1);

   jtm_host_s cur, nx;

   // ***************************************************
   //  next state
   // ***************************************************
   always_comb begin
      nx       = cur;
      nx.done  = 1'b0;
      nx.rdy_m = bus.ready;
      nx.rdy_s = cur.rdy_m;
      nx.dat_m = bus.host_data_bus;
      nx.dat_s = cur.dat_m;
      unique case (cur.st)
         JTM_HO_IDLE: begin
            if (req_i) begin
               nx.idx   = idx_i;
               nx.rw    = rd_i;
               nx.wdata = wdata_i;
               nx.oe_n  = rd_i;
               nx.busy  = 1'b1;
               nx.st    = JTM_HO_SETUP;
            end
         end
         JTM_HO_SETUP: begin
            nx.strobe_n = 1'b0;
            nx.cnt      = '0;
            nx.st       = JTM_HO_LOW;
         end
         JTM_HO_LOW: begin
            if (cur.cnt < LOW_LAST) begin
               nx.cnt = cur.cnt + HOST_CNT_ONE;
            end else if (cur.rdy_s) begin
               if (cur.rw) begin
                  nx.rdata = cur.dat_s;
               end
               nx.strobe_n = 1'b1;
               nx.cnt      = '0;
               nx.st       = JTM_HO_HIGH;
            end
         end
         JTM_HO_HIGH: begin
            if (cur.cnt < HIGH_LAST) begin
               nx.cnt = cur.cnt + HOST_CNT_ONE;
            end else begin
               nx.oe_n = 1'b1;
               nx.rw   = 1'b1;
               nx.busy = 1'b0;
               nx.done = 1'b1;
               nx.st   = JTM_HO_IDLE;
            end
         end
      endcase
   end

   // ***************************************************
   //  registers
   // ***************************************************
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cur <= HOST_RST;
      end else begin
         cur <= nx;
      end
   end

   assign bus.host_access_strobe_n = cur.strobe_n;
   assign bus.rw                   = cur.rw;
   assign bus.host_register_index  = cur.idx;
   assign bus.host_out             = cur.wdata;
   assign bus.host_oe_n            = cur.oe_n;
   assign busy_o                   = cur.busy;
   assign done_o                   = cur.done;
   assign rdata_o                  = cur.rdata;
endmodule // jtm_host

//--- testbench/jtm_asserts.sv
`timescale 1ns/1ns
module jtm_asserts
   import jtm_pkg::*;
(
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic host_access_strobe_n,
   input wire logic rw,
   input wire logic ready,
   input wire logic dev_oe_n,
   input wire logic tck_o,
   input wire logic tms_o,
   input wire logic tdo_o,
   input wire logic trst_o,
   input wire logic tap_output_enable_n_i,
   input wire logic tap_oe_n_o
);
   // ************************************************
   //  host port
   // ************************************************
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);

   // a write cycle must never see the device on the bus
   property p_wr_quiet;
      !rw |-> dev_oe_n;
   endproperty
   a_wr_quiet: assert property (p_wr_quiet)
      else $error("device drives bus during write");

   property p_idle_quiet;
      host_access_strobe_n [*5] |-> dev_oe_n;
   endproperty
   a_idle_quiet: assert property (p_idle_quiet)
      else $error("device drives bus with strobe high");

   property p_end_ready;
      $rose(host_access_strobe_n) |-> ##[1:5] ready;
   endproperty
   a_end_ready: assert property (p_end_ready)
      else $error("ready not back after strobe rise");

   property p_hold_off;
      $fell(ready) |-> !host_access_strobe_n && !$past(host_access_strobe_n, 3);
   endproperty
   a_hold_off: assert property (p_hold_off)
      else $error("ready dropped outside an access");

   // reset state is checked while reset is low, so no disable here
   property p_rst_pins;
      disable iff (1'b0) !arst_n_i |-> ready && tms_o && tdo_o && trst_o;
   endproperty
   a_rst_pins: assert property (p_rst_pins)
      else $error("outputs not high in reset");

   // ************************************************
   //  tap side
   // ************************************************
   property p_tap_edge;
      $changed(tdo_o) || $changed(tms_o) |-> $fell(tck_o);
   endproperty
   a_tap_edge: assert property (p_tap_edge)
      else $error("tdo or tms moved off falling tck");

   property p_tap_off;
      tap_output_enable_n_i [*4] |-> tap_oe_n_o;
   endproperty
   a_tap_off: assert property (p_tap_off)
      else $error("tap pins not released");

   property p_tap_on;
      !tap_output_enable_n_i [*4] |-> !tap_oe_n_o;
   endproperty
   a_tap_on: assert property (p_tap_on)
      else $error("tap pins not driven");

   property p_trst_src;
      $fell(trst_o) |-> !host_access_strobe_n && !rw;
   endproperty
   a_trst_src: assert property (p_trst_src)
      else $error("trst fell outside a host write");

   c_blocked: cover property ($fell(ready));
   c_trst:    cover property ($fell(trst_o));
   c_read:    cover property (!dev_oe_n);
endmodule // jtm_asserts

//--- testbench/tb.sv
`timescale 1ns/1ns
module tb;
   import jtm_pkg::*;
   // ************************************************
   //  signals and parts
   // ************************************************
   logic              clk_i    = 1'b0;
   logic              arst_n_i = 1'b1;
   logic              req      = 1'b0;
   logic              rd       = 1'b0;
   logic [IDX_W-1:0]  idx      = 3'h0;
   logic [DATA_W-1:0] wd       = 8'h00;
   logic              tap_en_n = 1'b0;
   logic              busy, done, tck, tms, tdo, trst, tap_oe_n;
   logic [DATA_W-1:0] rdata;
   int                fails      = 0;
   int                n_compared = 0;
   int                r;

   jtm_if bif ();
   always #50 clk_i = ~clk_i;

   jtm_host u_jtm_host (.clk_i(clk_i), .arst_n_i(arst_n_i), .bus(bif),
      .req_i(req), .rd_i(rd), .idx_i(idx), .wdata_i(wd),
      .busy_o(busy), .done_o(done), .rdata_o(rdata));
   // tdo looped back to tdi so a scan returns its own byte
   jtm_device u_jtm_device (.clk_i(clk_i), .arst_n_i(arst_n_i),
      .bus(bif), .tdi_i(tdo), .tap_output_enable_n_i(tap_en_n),
      .tck_o(tck), .tms_o(tms), .tdo_o(tdo), .trst_o(trst),
      .tap_oe_n_o(tap_oe_n));
   jtm_asserts u_jtm_asserts (.clk_i(clk_i), .arst_n_i(arst_n_i),
      .host_access_strobe_n(bif.host_access_strobe_n), .rw(bif.rw),
      .ready(bif.ready), .dev_oe_n(bif.dev_oe_n), .tck_o(tck),
      .tms_o(tms), .tdo_o(tdo), .trst_o(trst),
      .tap_output_enable_n_i(tap_en_n), .tap_oe_n_o(tap_oe_n));

   // ************************************************
   //  tasks
   // ************************************************
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH %0t: seen %h want %h", $time, seen, exp);
      end
   endtask

   // one host access; bounded wait on done
   task automatic acc(input logic r_w, input logic [2:0] i,
                      input logic [7:0] d);
      int n;
      n = 0;
      @(negedge clk_i);
      req = 1'b1;
      rd = r_w;
      idx = i;
      wd = d;
      @(negedge clk_i);
      req = 1'b0;
      while (done !== 1'b1 && n < 500) begin
         @(negedge clk_i);
         n++;
      end
      chk({6'h0, busy, done}, 8'h01);
   endtask

   task automatic rdchk(input logic [2:0] i, input logic [7:0] exp);
      acc(1'b1, i, 8'h00);
      chk(rdata, exp);
   endtask

   // counts tck rises seen at falling clock edges
   task automatic rises(input int n, output int c);
      logic p;
      c = 0;
      p = tck;
      repeat (n) begin
         @(negedge clk_i);
         if (tck === 1'b1 && p === 1'b0) c++;
         p = tck;
      end
   endtask

   task automatic tend(input string s);
      $display("test %s done", s);
   endtask

   task automatic report_and_stop;
      $display("compared %0d, mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   // ************************************************
   //  tests
   // ************************************************
   initial begin
      // a real falling edge, so the async reset branch fires
      #10 arst_n_i = 1'b0;
      repeat (5) @(negedge clk_i);
      arst_n_i = 1'b1;
      repeat (3) @(negedge clk_i);
      rdchk(IDX_DIV, DIV_RST);
      rdchk(IDX_LEN, LEN_RST);
      rises(32, r);
      chk(8'(r), 8'h00);
      tend("reset values");
      acc(1'b0, IDX_DIV, 8'h00);
      rdchk(IDX_DIV, DIV_MIN);
      acc(1'b0, IDX_DIV, 8'h03);
      rdchk(IDX_DIV, 8'h03);
      tend("divisor");
      acc(1'b0, IDX_CMD, 8'h01);
      chk({7'h0, trst}, 8'h00);
      rdchk(IDX_CMD, 8'h01);
      acc(1'b0, IDX_CMD, 8'h00);
      chk({7'h0, trst}, 8'h01);
      tend("trst");
      // read while the scan runs is held off, then completes
      acc(1'b0, IDX_SCAN, 8'ha5);
      rdchk(IDX_SCAN, 8'ha5);
      chk({7'h0, tck}, 8'h01);
      // last bit seen was a5 bit 7; engine idle in gated mode
      rdchk(IDX_STAT, 8'h02);
      tend("scan");
      acc(1'b0, IDX_MODE, {6'h0, MODE_DISC});
      acc(1'b0, IDX_DISC, 8'h07);
      chk({4'h0, tck, trst, tdo, tms}, 8'h07);
      rdchk(IDX_DISC, 8'h01);
      chk({7'h0, tck}, 8'h01);
      acc(1'b0, IDX_DISC, 8'h00);
      chk({4'h0, tck, trst, tdo, tms}, 8'h00);
      tend("discrete");
      acc(1'b0, IDX_MODE, {6'h0, MODE_FREE});
      rises(64, r);
      chk(8'(r), 8'h08);
      tend("free run");
      tap_en_n = 1'b1;
      repeat (5) @(negedge clk_i);
      chk({7'h0, tap_oe_n}, 8'h01);
      tap_en_n = 1'b0;
      repeat (5) @(negedge clk_i);
      chk({7'h0, tap_oe_n}, 8'h00);
      tend("tap enable");
      // mid-run reset: pins high, tck at clock over sixteen
      arst_n_i = 1'b0;
      @(negedge clk_i);
      chk({4'h0, bif.ready, tms, tdo, trst}, 8'h0f);
      repeat (3) @(negedge clk_i);
      rises(64, r);
      chk(8'(r), 8'h04);
      arst_n_i = 1'b1;
      repeat (3) @(negedge clk_i);
      rdchk(IDX_MODE, 8'h00);
      rdchk(IDX_CMD, 8'h00);
      tend("second reset");
      report_and_stop;
   end

   // watchdog well beyond the several hundred cycles the tests need
   initial begin
      repeat (20000) @(posedge clk_i);
      fails++;
      $display("MISMATCH %0t: watchdog expired", $time);
      report_and_stop;
   end
endmodule // tb
